// ### logic/mpp_mode_ctrl.sv
`timescale 1ns/1ps
module mpp_mode_ctrl (
  input wire logic ref_clk_i, // Device clock, 100 MHz.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic master_reset_pin_n_i, // Master reset pin, active low.
  input wire mpp_pkg::mpp_bus_req_type bus_req_i, // Register port request.
  output logic [mpp_pkg::DATA_W-1:0] bus_rdata_o, // Read data, cycle after read.
  input wire mpp_pkg::mpp_msg_start_type msg_start_i, // New command for this mode code.
  input wire mpp_pkg::mpp_msg_end_type msg_end_i, // Message completion.
  output logic msg_busy_o, // A message is in progress.
  output logic buf_pingpong_o, // Current message uses ping-pong handling.
  output logic buf_ptr_b_o, // Current message uses pointer B.
  output logic irq_o // Interrupt request, active high.
);
  import mpp_pkg::*;

  typedef struct packed {
    logic broadcast_received;
    logic pingpong_active_ack;
    logic pingpong_stop_request;
    logic pingpong_buffer_enable;
    logic next_buffer_select;
    logic busy;
    logic cur_pingpong;
    logic cur_ptr_b;
    logic broadcast_invalidate;
    logic terminal_enable;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } mpp_state_type;

  localparam mpp_state_type STATE_RESET = '{
    broadcast_received: 1'b0,
    pingpong_active_ack: 1'b0,
    pingpong_stop_request: 1'b0,
    pingpong_buffer_enable: 1'b0,
    next_buffer_select: 1'b0,
    busy: 1'b0,
    cur_pingpong: 1'b0,
    cur_ptr_b: 1'b0,
    broadcast_invalidate: 1'b0,
    terminal_enable: 1'b0,
    irq_mask: IRQ_ZERO,
    irq: 1'b0,
    rdata: DATA_ZERO
  };

  function automatic logic is_hit(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] ofs);
    is_hit = (addr == ofs);
  endfunction : is_hit

  function automatic logic is_broadcast_received_addr(input logic [RT_ADDR_W-1:0] rt_addr);
    is_broadcast_received_addr = (rt_addr == BROADCAST_RECEIVED_RT_ADDR);
  endfunction : is_broadcast_received_addr

  mpp_state_type st;
  mpp_state_type next_st;

  logic master_reset_n_sync;
  logic soft_reset;
  logic ctrl_clear;
  logic accept;
  logic finish;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_status;
  logic irq_any;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] cfg_word;

  mpp_sync2 u_mr_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(master_reset_pin_n_i),
    .sync_o(master_reset_n_sync)
  );

  // The soft reset bit is a command: it acts in the cycle it is written and never stores.
  assign soft_reset = bus_req_i.wr && is_hit(bus_req_i.addr, OFS_CFG)
                      && bus_req_i.wdata[CFG_BIT_SOFT_RESET_CMD];
  assign ctrl_clear = soft_reset || !master_reset_n_sync;

  // Commands to address 31 are not valid while invalidation is on.
  assign accept = msg_start_i.start && !st.busy
                  && !(st.broadcast_invalidate && is_broadcast_received_addr(msg_start_i.rt_addr));
  assign finish = msg_end_i.done && st.busy;
  assign irq_any = |(irq_status & st.irq_mask);

  always_comb
  begin
    ctrl_word = DATA_ZERO;
    ctrl_word[BIT_SELECT] = st.next_buffer_select;
    ctrl_word[BIT_BROADCAST_RECEIVED] = st.broadcast_received;
    ctrl_word[BIT_ACK] = st.pingpong_active_ack;
    ctrl_word[BIT_STOP] = st.pingpong_stop_request;
    ctrl_word[BIT_ENABLE] = st.pingpong_buffer_enable;
    cfg_word = DATA_ZERO;
    cfg_word[CFG_BIT_BINV] = st.broadcast_invalidate;
    cfg_word[CFG_BIT_TEN] = st.terminal_enable;
  end

  always_comb
  begin
    next_st = st;
    if (bus_req_i.wr && is_hit(bus_req_i.addr, OFS_CTRL))
    begin
      next_st.pingpong_stop_request = bus_req_i.wdata[BIT_STOP];
      // Enable writes are dropped unless the terminal is enabled.
      if (st.terminal_enable)
      begin
        next_st.pingpong_buffer_enable = bus_req_i.wdata[BIT_ENABLE];
      end
    end
    if (bus_req_i.wr && is_hit(bus_req_i.addr, OFS_CFG))
    begin
      next_st.broadcast_invalidate = bus_req_i.wdata[CFG_BIT_BINV];
      next_st.terminal_enable = bus_req_i.wdata[CFG_BIT_TEN];
    end
    if (bus_req_i.wr && is_hit(bus_req_i.addr, OFS_IRQ_MASK))
    begin
      next_st.irq_mask = bus_req_i.wdata[IRQ_W-1:0];
    end
    // The acknowledge follows the request only while no message is open.
    if (!st.busy && !msg_start_i.start)
    begin
      next_st.pingpong_active_ack = st.pingpong_buffer_enable
                                    && !st.pingpong_stop_request;
    end
    if (accept)
    begin
      next_st.busy = 1'b1;
      // Ping-pong only while enabled and acknowledged.
      next_st.cur_pingpong = st.pingpong_buffer_enable && st.pingpong_active_ack;
      // Suspended or indexed handling uses the pointer the selector names.
      next_st.cur_ptr_b = st.next_buffer_select;
      if (is_broadcast_received_addr(msg_start_i.rt_addr) && msg_start_i.broadcast_tr)
      begin
        next_st.broadcast_received = 1'b1;
      end
    end
    if (finish)
    begin
      next_st.busy = 1'b0;
      // The selector only moves for clean ping-pong messages.
      if (st.cur_pingpong && msg_end_i.error_free)
      begin
        next_st.next_buffer_select = !st.next_buffer_select;
      end
    end
    next_st.rdata = DATA_ZERO;
    if (bus_req_i.rd)
    begin
      if (is_hit(bus_req_i.addr, OFS_CTRL))
      begin
        next_st.rdata = ctrl_word;
      end
      else if (is_hit(bus_req_i.addr, OFS_CFG))
      begin
        next_st.rdata = cfg_word;
      end
      else if (is_hit(bus_req_i.addr, OFS_IRQ_STAT))
      begin
        next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
      end
      else if (is_hit(bus_req_i.addr, OFS_IRQ_MASK))
      begin
        next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_mask};
      end
    end
    // Either reset source wipes the control word and aborts an open message.
    if (ctrl_clear)
    begin
      next_st.broadcast_received = 1'b0;
      next_st.pingpong_active_ack = 1'b0;
      next_st.pingpong_stop_request = 1'b0;
      next_st.pingpong_buffer_enable = 1'b0;
      next_st.next_buffer_select = 1'b0;
      next_st.busy = 1'b0;
      next_st.cur_pingpong = 1'b0;
      next_st.cur_ptr_b = 1'b0;
    end
    // The interrupt trails the status by one cycle so that it leaves a flip-flop.
    next_st.irq = irq_any;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    irq_set = IRQ_ZERO;
    irq_set[IRQ_BROADCAST_RECEIVED] = next_st.broadcast_received && !st.broadcast_received;
    irq_set[IRQ_ACK_ON] = next_st.pingpong_active_ack && !st.pingpong_active_ack;
    irq_set[IRQ_ACK_OFF] = !next_st.pingpong_active_ack && st.pingpong_active_ack;
    irq_set[IRQ_DONE] = finish && !ctrl_clear;
    irq_clr = IRQ_ZERO;
    if (bus_req_i.wr && is_hit(bus_req_i.addr, OFS_IRQ_STAT))
    begin
      irq_clr = bus_req_i.wdata[IRQ_W-1:0];
    end
  end

  mpp_sticky_status u_irq_status (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .status_o(irq_status)
  );

  assign bus_rdata_o = st.rdata;
  assign msg_busy_o = st.busy;
  assign buf_pingpong_o = st.cur_pingpong;
  assign buf_ptr_b_o = st.cur_ptr_b;
  assign irq_o = st.irq;

  AST_BROADCAST_RECEIVED_SET: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    accept && is_broadcast_received_addr(msg_start_i.rt_addr) && msg_start_i.broadcast_tr && !ctrl_clear
    |=> st.broadcast_received && st.busy)
    else $error("broadcast flag not set by valid broadcast transmit command");

  AST_BINV_REJECT: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    msg_start_i.start && !st.busy && st.broadcast_invalidate && !ctrl_clear
    && is_broadcast_received_addr(msg_start_i.rt_addr)
    |=> !st.busy && $stable(st.broadcast_received))
    else $error("address 31 command accepted while invalidated");

  AST_RESET_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ctrl_clear |=> !st.broadcast_received && !st.next_buffer_select && !st.busy)
    else $error("control word not cleared by reset");

  AST_ACK_ON: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !st.busy && !msg_start_i.start && !ctrl_clear
    && st.pingpong_buffer_enable && !st.pingpong_stop_request
    |=> st.pingpong_active_ack)
    else $error("acknowledge not set while ping-pong active");

  AST_ACK_OFF: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(st.pingpong_stop_request) && !st.busy && !msg_start_i.start
    |=> !st.pingpong_active_ack)
    else $error("acknowledge not cleared after stop request");

  AST_ACK_RESUME: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $fell(st.pingpong_stop_request) && st.pingpong_buffer_enable
    && !st.busy && !msg_start_i.start && !ctrl_clear
    |=> st.pingpong_active_ack)
    else $error("acknowledge not restored after stop request removed");

  AST_SINGLE_BUF: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    accept && !ctrl_clear && st.pingpong_buffer_enable && !st.pingpong_active_ack
    |=> !st.cur_pingpong && (st.cur_ptr_b == $past(st.next_buffer_select)))
    else $error("suspended command not handled as single buffer");

  AST_SEL_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    finish && !st.cur_pingpong && !ctrl_clear
    |=> $stable(st.next_buffer_select))
    else $error("selector moved while suspended");

  AST_PP_MODE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    accept && !ctrl_clear
    |=> st.cur_pingpong == ($past(st.pingpong_buffer_enable) && $past(st.pingpong_active_ack)))
    else $error("buffer mode does not follow enable");

  AST_SEL_TOGGLE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    finish && st.cur_pingpong && msg_end_i.error_free && !ctrl_clear
    |=> st.next_buffer_select != $past(st.next_buffer_select))
    else $error("selector not toggled after clean ping-pong message");

  AST_ACK_FROZEN: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    st.busy && !ctrl_clear |=> $stable(st.pingpong_active_ack))
    else $error("acknowledge changed during a message");

  AST_IRQ_LEVEL: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ##1 (irq_o == $past(irq_any)))
    else $error("interrupt output does not follow masked status");

  // A receive-direction command to address 31 must leave the broadcast flag alone.
  AST_BROADCAST_RECEIVED_NEEDS_TR: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    accept && !msg_start_i.broadcast_tr && !st.broadcast_received && !ctrl_clear
    |=> !st.broadcast_received)
    else $error("broadcast flag set by receive command");

  AST_ENABLE_GATED: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_req_i.wr && is_hit(bus_req_i.addr, OFS_CTRL) && !st.terminal_enable && !ctrl_clear
    |=> $stable(st.pingpong_buffer_enable))
    else $error("buffer enable written while terminal disabled");

  AST_CTRL_CLEAR_HS: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ctrl_clear |=> !st.pingpong_buffer_enable && !st.pingpong_active_ack
    && !st.pingpong_stop_request && !st.cur_pingpong)
    else $error("handshake bits not cleared by reset");

  // Read data must not linger, or a stale word could be taken for a fresh read.
  AST_RDATA_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !bus_req_i.rd |=> bus_rdata_o == DATA_ZERO)
    else $error("read data present without a read");

  AST_START_REFUSED: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    st.busy && msg_start_i.start && !finish && !ctrl_clear
    |=> st.busy && $stable(st.cur_ptr_b) && $stable(st.cur_pingpong))
    else $error("start accepted while a message is open");

endmodule : mpp_mode_ctrl

// ### logic/mpp_pkg.sv
package mpp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RT_ADDR_W = 5;
  localparam int unsigned IRQ_W = 4;

  // Byte addresses of the register words on the plain register port.
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;

  // Field positions inside mode_code_control_word.
  localparam int unsigned BIT_SELECT = 10;
  localparam int unsigned BIT_BROADCAST_RECEIVED = 9;
  localparam int unsigned BIT_ACK = 8;
  localparam int unsigned BIT_STOP = 3;
  localparam int unsigned BIT_ENABLE = 2;

  // Field positions inside the configuration word.
  localparam int unsigned CFG_BIT_BINV = 0;
  localparam int unsigned CFG_BIT_TEN = 1;
  localparam int unsigned CFG_BIT_SOFT_RESET_CMD = 2;

  // Interrupt status and mask layout.
  localparam int unsigned IRQ_BROADCAST_RECEIVED = 0;
  localparam int unsigned IRQ_ACK_ON = 1;
  localparam int unsigned IRQ_ACK_OFF = 2;
  localparam int unsigned IRQ_DONE = 3;

  localparam logic [RT_ADDR_W-1:0] BROADCAST_RECEIVED_RT_ADDR = 5'h1f;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 4'h0;
  localparam logic SYNC_IDLE = 1'b1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mpp_bus_req_type;

  typedef struct packed {
    logic start;
    logic broadcast_tr;
    logic [RT_ADDR_W-1:0] rt_addr;
  } mpp_msg_start_type;

  typedef struct packed {
    logic done;
    logic error_free;
  } mpp_msg_end_type;

endpackage : mpp_pkg

// ### logic/mpp_sync2.sv
`timescale 1ns/1ps
module mpp_sync2 (
  input wire logic ref_clk_i, // Device clock.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic async_i, // Level from outside the clock domain.
  output logic sync_o // Level after two flip-flops.
);
  import mpp_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } mpp_sync_state_type;

  mpp_sync_state_type st;
  mpp_sync_state_type next_st;

  always_comb
  begin
    next_st = st;
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= {SYNC_IDLE, SYNC_IDLE};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule : mpp_sync2

// ### logic/mpp_sticky_status.sv
`timescale 1ns/1ps
module mpp_sticky_status (
  input wire logic ref_clk_i, // Device clock.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic [mpp_pkg::IRQ_W-1:0] set_i, // Event pulses.
  input wire logic [mpp_pkg::IRQ_W-1:0] clr_i, // Write-one-to-clear mask.
  output logic [mpp_pkg::IRQ_W-1:0] status_o // Sticky status bits.
);
  import mpp_pkg::*;

  typedef struct packed {
    logic [IRQ_W-1:0] status;
  } mpp_sticky_state_type;

  mpp_sticky_state_type st;
  mpp_sticky_state_type next_st;

  // A set in the same cycle as its clear wins so no event is lost.
  always_comb
  begin
    next_st = st;
    next_st.status = (st.status & ~clr_i) | set_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '{status: IRQ_ZERO};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign status_o = st.status;

endmodule : mpp_sticky_status

// ### test/mpp_host_model.sv
`timescale 1ns/1ps
module mpp_host_model (
  input wire logic ref_clk_i, // Device clock.
  output mpp_pkg::mpp_bus_req_type bus_req_o, // Register port request.
  input wire logic [mpp_pkg::DATA_W-1:0] bus_rdata_i // Read data, cycle after read.
);
  import mpp_pkg::*;

  // Shadow of the terminal enable, so the enable bit is written as zero while it is clear.
  logic ten_shadow;

  initial
  begin
    bus_req_o <= '0;
    ten_shadow = 1'b0;
  end

  task write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (a == OFS_CTRL && !ten_shadow) v[BIT_ENABLE] = 1'b0;
    if (a == OFS_CFG) ten_shadow = d[CFG_BIT_TEN];
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk_i);
    // Released lines carry the inverse so a stale value is never mistaken for a live one.
    bus_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask : write_reg

  task read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: bus_req_o.wdata};
    @(posedge ref_clk_i);
    bus_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: bus_req_o.wdata};
    #1 d = bus_rdata_i;
  endtask : read_reg

  // The buffer is touched only when the acknowledge reads cleared.
  task service_buffer(output logic ok);
    logic [DATA_W-1:0] v;
    read_reg(OFS_CTRL, v);
    ok = !v[BIT_ACK];
  endtask : service_buffer
endmodule : mpp_host_model

// ### test/mpp_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
module mpp_mode_ctrl_tb_top;
  import mpp_pkg::*;

  logic ref_clk_i;
  logic sys_rst_i;
  logic master_reset_pin_n_i;
  mpp_bus_req_type bus_req;
  logic [DATA_W-1:0] bus_rdata;
  mpp_msg_start_type msg_start;
  mpp_msg_end_type msg_end;
  logic msg_busy;
  logic buf_pingpong;
  logic buf_ptr_b;
  logic irq;
  logic [DATA_W-1:0] rd;
  logic ok;
  int failures = 0;
  int comparisons = 0;

  mpp_mode_ctrl dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .master_reset_pin_n_i(master_reset_pin_n_i), .bus_req_i(bus_req),
    .bus_rdata_o(bus_rdata), .msg_start_i(msg_start), .msg_end_i(msg_end),
    .msg_busy_o(msg_busy), .buf_pingpong_o(buf_pingpong), .buf_ptr_b_o(buf_ptr_b),
    .irq_o(irq));

  mpp_host_model host (.ref_clk_i(ref_clk_i), .bus_req_o(bus_req), .bus_rdata_i(bus_rdata));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  function automatic logic [DATA_W-1:0] outs();
    return {13'h0000, msg_busy, buf_pingpong, buf_ptr_b};
  endfunction : outs

  task start_msg(input logic tr, input logic [RT_ADDR_W-1:0] rt);
    @(posedge ref_clk_i);
    msg_start <= '{start: 1'b1, broadcast_tr: tr, rt_addr: rt};
    @(posedge ref_clk_i);
    msg_start <= '{start: 1'b0, broadcast_tr: ~tr, rt_addr: ~rt};
    #1;
  endtask : start_msg

  task end_msg(input logic ef);
    @(posedge ref_clk_i);
    msg_end <= '{done: 1'b1, error_free: ef};
    @(posedge ref_clk_i);
    msg_end <= '{done: 1'b0, error_free: ~ef};
    #1;
  endtask : end_msg

  task t_reset;
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
    host.read_reg(8'h10, rd);
    check(rd, 16'h0000);
    host.write_reg(OFS_CTRL, 16'h0004);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
    start_msg(1'b0, 5'h01);
    check(outs(), 16'h0004);
    end_msg(1'b1);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
  endtask : t_reset

  task t_enable;
    host.write_reg(OFS_CFG, 16'h0002);
    host.write_reg(OFS_CTRL, 16'h0004);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0104);
    start_msg(1'b0, 5'h01);
    check(outs(), 16'h0006);
    end_msg(1'b1);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0504);
    start_msg(1'b0, 5'h01);
    check(outs(), 16'h0007);
    end_msg(1'b0);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0504);
  endtask : t_enable

  task t_stop;
    host.write_reg(OFS_CTRL, 16'h000c);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h040c);
    host.service_buffer(ok);
    check({15'h0000, ok}, 16'h0001);
    start_msg(1'b0, 5'h01);
    check(outs(), 16'h0005);
    end_msg(1'b1);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h040c);
    host.write_reg(OFS_CTRL, 16'h0004);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0504);
  endtask : t_stop

  task t_freeze;
    start_msg(1'b0, 5'h01);
    check(outs(), 16'h0007);
    start_msg(1'b1, BROADCAST_RECEIVED_RT_ADDR);
    check(outs(), 16'h0007);
    host.write_reg(OFS_CTRL, 16'h000c);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h050c);
    end_msg(1'b1);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h000c);
    host.write_reg(OFS_CTRL, 16'h0004);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0104);
  endtask : t_freeze

  task t_broadcast_received;
    check({15'h0000, irq}, 16'h0000);
    host.write_reg(OFS_IRQ_STAT, 16'h000f);
    host.write_reg(OFS_IRQ_MASK, 16'h0001);
    start_msg(1'b1, BROADCAST_RECEIVED_RT_ADDR);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0304);
    end_msg(1'b1);
    host.read_reg(OFS_IRQ_STAT, rd);
    check(rd, 16'h0009);
    repeat (2) @(posedge ref_clk_i);
    #1 check({15'h0000, irq}, 16'h0001);
    host.write_reg(OFS_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge ref_clk_i);
    #1 check({15'h0000, irq}, 16'h0000);
  endtask : t_broadcast_received

  task t_invalid;
    host.write_reg(OFS_CFG, 16'h0003);
    start_msg(1'b1, BROADCAST_RECEIVED_RT_ADDR);
    check(outs(), 16'h0002);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0704);
    host.write_reg(OFS_CFG, 16'h0006);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
    host.read_reg(OFS_CFG, rd);
    check(rd, 16'h0002);
    start_msg(1'b0, BROADCAST_RECEIVED_RT_ADDR);
    end_msg(1'b1);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
  endtask : t_invalid

  task t_mreset;
    host.write_reg(OFS_CTRL, 16'h0004);
    start_msg(1'b1, BROADCAST_RECEIVED_RT_ADDR);
    end_msg(1'b1);
    @(posedge ref_clk_i);
    master_reset_pin_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    master_reset_pin_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    host.read_reg(OFS_CTRL, rd);
    check(rd, 16'h0000);
    host.read_reg(OFS_IRQ_MASK, rd);
    check(rd, 16'h0001);
  endtask : t_mreset

  initial
  begin
    sys_rst_i <= 1'b1;
    master_reset_pin_n_i <= 1'b1;
    msg_start <= '0;
    msg_end <= '0;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_stop();
    t_freeze();
    t_broadcast_received();
    t_invalid();
    t_mreset();
    report_and_stop();
  end

  // The run needs about 140 cycles; the limit leaves ample margin.
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule : mpp_mode_ctrl_tb_top
